// >>> ccx_pkg.sv
// Constants, register map and state encoding for the context exchange sequencer
package ccx_pkg;
    localparam int WORDS      = 16;
    localparam int IDX_W      = 4;
    localparam int DATA_W     = 64;
    localparam int ADDR_W     = 22;
    localparam int PTR_W      = 8;
    localparam int P_W        = 24;
    localparam int FLAG_W     = 8;
    localparam int CNT_W      = 8;
    localparam int AXI_AW     = 8;
    localparam int AXI_DW     = 32;

    // Package word layout inside the 16-word block
    localparam int PTR_WORD   = 0;
    localparam int P_WORD     = 1;
    localparam int MODE_WORD  = 2;
    localparam int MON_BIT    = 0;
    localparam int WS_BIT     = 1;

    // Interrupt flag positions
    localparam int FLAG_MEM   = 0;
    localparam int FLAG_NEX   = 1;
    localparam int FLAG_EEX   = 2;
    localparam logic [FLAG_W-1:0] MON_ALLOW = 8'h07;

    // Timing, in clock periods and in cycles of the 20 MHz clock
    localparam int CP_NS         = 50;
    localparam int CLOCK_NS      = 50;
    localparam int SWAP_MIN_CP   = 40;
    localparam int FETCH_MIN_CP  = 39;
    localparam int SWITCH_MIN_CP = 83;
    localparam int SWAP_MIN_CYC   = (SWAP_MIN_CP * CP_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int SWITCH_MIN_CYC = (SWITCH_MIN_CP * CP_NS + CLOCK_NS - 1) / CLOCK_NS;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFF_STATUS  = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_FLAGS   = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_POINTER = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_LASTLEN = 8'h0C;
    localparam logic [AXI_AW-1:0] OFF_COUNT   = 8'h10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_HOLD  = 3'h1,
        ST_READ  = 3'h3,
        ST_WRITE = 3'h2,
        ST_PAD   = 3'h6,
        ST_FETCH = 3'h7
    } ccx_state_type;
endpackage

// >>> ccx_sequencer.sv
// Context exchange sequencer with AXI4-Lite register slave
// Overview of operation
// - Swap active and stored package, one block
// - Sixteen reads and sixteen writes per swap
// - Word n exchanges with word n, from zero
// - Block address from pointer; zero for deadstart, scan, interprocessor start
// - Wait for memory and register activity
// - Whole switch lasts at least 83 cycles
// - Stalled test-and-set clears both parcel registers
// - Saved package: wait flag, address of test-and-set
// - Only deadstart, interprocessor start, exits or interrupts start swaps
// - Deadstart forces pointer zero; loader fills zero
// - Reset reaches every flop; scan releases idle
// - Scan-forced interrupt swaps in package zero
// - Package written back at zero is indeterminate
// - Interprocessor start swaps in package zero
// - Both exits swap, same pointer
// - Exit flag set only outside monitor mode
// - Outside monitor mode, any set interrupt flag starts a swap
// - Monitor mode: only memory interrupt ends interval
// - Non-monitor code cannot change the pointer
// - No interlock against other processors' transfers
// - Swap clears all buffer tag valid bits
// - Monitor mode masks all but the memory flag
`timescale 1ns/1ns
module ccx_sequencer (
    input  wire logic                       i_clock,
    input  wire logic                       i_srst,
    input  wire logic                       i_deadstart,
    input  wire logic                       i_scan_intr,
    input  wire logic                       i_ipi_start,
    input  wire logic                       i_exit_normal,
    input  wire logic                       i_exit_error,
    input  wire logic [ccx_pkg::FLAG_W-1:0] i_intr_flags,
    input  wire logic                       i_mem_pending,
    input  wire logic                       i_reg_busy,
    input  wire logic                       i_tas_holding,
    input  wire logic [ccx_pkg::P_W-1:0]    i_tas_addr,
    input  wire logic [ccx_pkg::P_W-1:0]    i_prog_addr,
    input  wire logic                       i_fetch_done,
    input  wire logic                       i_mem_ack,
    input  wire logic [ccx_pkg::DATA_W-1:0] i_mem_rdata,
    output logic                            o_mem_req,
    output logic                            o_mem_we,
    output logic [ccx_pkg::ADDR_W-1:0]      o_mem_addr,
    output logic [ccx_pkg::DATA_W-1:0]      o_mem_wdata,
    output logic                            o_parcel_clear,
    output logic                            o_tag_clear,
    output logic                            o_fetch_start,
    output logic [ccx_pkg::P_W-1:0]         o_fetch_addr,
    output logic                            o_busy,
    output logic                            o_monitor,
    input  wire logic [ccx_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [ccx_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [ccx_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [ccx_pkg::AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import ccx_pkg::*;

    ccx_state_type            st_r, st_nxt;
    logic [DATA_W-1:0]        ctx_r [WORDS];
    logic [DATA_W-1:0]        ctx_nxt [WORDS];
    logic [DATA_W-1:0]        rd_word_r, rd_word_nxt;
    logic [IDX_W-1:0]         idx_r, idx_nxt;
    logic [CNT_W-1:0]         cnt_r, cnt_nxt;
    logic [PTR_W-1:0]         base_r, base_nxt;
    logic                     zero_r, zero_nxt;
    logic                     stale_r, stale_nxt;
    logic [15:0]              count_r, count_nxt;
    logic [CNT_W-1:0]         last_r, last_nxt;
    logic                     req_r, req_nxt, we_r, we_nxt;
    logic [ADDR_W-1:0]        addr_r, addr_nxt;
    logic [DATA_W-1:0]        wdata_r, wdata_nxt;
    logic                     pclr_r, pclr_nxt, tclr_r, tclr_nxt;
    logic                     fst_r, fst_nxt;
    logic [P_W-1:0]           faddr_r, faddr_nxt;
    logic                     busy_r, busy_nxt;
    logic [FLAG_W-1:0]        flags_r, flags_nxt, flag_set;
    logic                     monitor, start_zero, exit_any, intr_req, hold_go;
    logic [PTR_W-1:0]         pointer;
    // Bus slave state
    logic                     awh_r, awh_nxt, wh_r, wh_nxt;
    logic [AXI_AW-1:0]        awaddr_r, awaddr_nxt;
    logic [AXI_DW-1:0]        wdat_r, wdat_nxt;
    logic                     wstb_r, wstb_nxt;
    logic                     bvalid_r, bvalid_nxt;
    logic [1:0]               bresp_r, bresp_nxt;
    logic                     rvalid_r, rvalid_nxt;
    logic [1:0]               rresp_r, rresp_nxt;
    logic [AXI_DW-1:0]        rdata_r, rdata_nxt;
    logic                     wr_fire, wr_ptr, wr_flags;

    assign monitor    = ctx_r[MODE_WORD][MON_BIT];
    assign pointer    = ctx_r[PTR_WORD][PTR_W-1:0];
    assign start_zero = i_deadstart | i_scan_intr | i_ipi_start;
    assign exit_any   = i_exit_normal | i_exit_error;
    // Monitor mode: only a memory error interrupts; exits still swap on their own
    // path, so a leftover exit flag cannot end the monitor's interval
    assign intr_req   = monitor ? flags_r[FLAG_MEM] : |flags_r;
    assign hold_go    = !i_mem_pending && !i_reg_busy;
    assign wr_fire    = awh_r && wh_r && !bvalid_r;
    assign wr_ptr     = wr_fire && wstb_r && awaddr_r == OFF_POINTER;
    assign wr_flags   = wr_fire && wstb_r && awaddr_r == OFF_FLAGS;

    // Exit flags only outside monitor mode; a new set beats a clear
    always_comb begin
        flag_set           = i_intr_flags;
        flag_set[FLAG_NEX] = i_intr_flags[FLAG_NEX] | (i_exit_normal & !monitor);
        flag_set[FLAG_EEX] = i_intr_flags[FLAG_EEX] | (i_exit_error & !monitor);
        flags_nxt          = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_r & ~wdat_r[FLAG_W-1:0];
        end
        flags_nxt = flags_nxt | flag_set;
    end

    always_comb begin
        st_nxt      = st_r;
        ctx_nxt     = ctx_r;
        rd_word_nxt = rd_word_r;
        idx_nxt     = idx_r;
        cnt_nxt     = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
        base_nxt    = base_r;
        zero_nxt    = zero_r;
        stale_nxt   = stale_r;
        count_nxt   = count_r;
        last_nxt    = last_r;
        req_nxt     = req_r;
        we_nxt      = we_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        pclr_nxt    = 1'b0;
        tclr_nxt    = 1'b0;
        fst_nxt     = 1'b0;
        faddr_nxt   = faddr_r;
        busy_nxt    = st_r != ST_IDLE;
        // Pointer changes only from monitor code, and never mid-swap
        if (wr_ptr && monitor && st_r == ST_IDLE) begin
            ctx_nxt[PTR_WORD][PTR_W-1:0] = wdat_r[PTR_W-1:0];
            stale_nxt = 1'b0;
        end
        case (st_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (start_zero || exit_any || intr_req) begin
                    st_nxt   = ST_HOLD;
                    busy_nxt = 1'b1;
                    zero_nxt = start_zero;
                end
                if (i_deadstart) begin
                    ctx_nxt[PTR_WORD][PTR_W-1:0] = '0;
                end
            end
            ST_HOLD: begin
                cnt_nxt = '0;
                if (hold_go) begin
                    st_nxt   = ST_READ;
                    base_nxt = zero_r ? '0 : pointer;
                    idx_nxt  = '0;
                    ctx_nxt[P_WORD][P_W-1:0] = i_tas_holding ? i_tas_addr : i_prog_addr;
                    ctx_nxt[MODE_WORD][WS_BIT] = i_tas_holding;
                    pclr_nxt = i_tas_holding;
                    tclr_nxt = 1'b1;
                    // No lock is taken against other requesters of this block
                    req_nxt  = 1'b1;
                    we_nxt   = 1'b0;
                    // Block sits in the lowest 4096 words by construction
                    addr_nxt = {{(ADDR_W-PTR_W-IDX_W){1'b0}},
                                (zero_r ? {PTR_W{1'b0}} : pointer), {IDX_W{1'b0}}};
                end
            end
            ST_READ: begin
                if (i_mem_ack) begin
                    rd_word_nxt = i_mem_rdata;
                    st_nxt      = ST_WRITE;
                    we_nxt      = 1'b1;
                    wdata_nxt   = ctx_r[idx_r];
                end
            end
            ST_WRITE: begin
                if (i_mem_ack) begin
                    ctx_nxt[idx_r] = rd_word_r;
                    if (idx_r == IDX_W'(WORDS - 1)) begin
                        st_nxt  = ST_PAD;
                        req_nxt = 1'b0;
                        we_nxt  = 1'b0;
                    end else begin
                        st_nxt   = ST_READ;
                        idx_nxt  = idx_r + 1'b1;
                        we_nxt   = 1'b0;
                        addr_nxt = {{(ADDR_W-PTR_W-IDX_W){1'b0}}, base_r, idx_r + 1'b1};
                    end
                end
            end
            ST_PAD: begin
                if (cnt_r >= CNT_W'(SWAP_MIN_CYC - 1)) begin
                    st_nxt    = ST_FETCH;
                    fst_nxt   = 1'b1;
                    faddr_nxt = ctx_r[P_WORD][P_W-1:0];
                end
            end
            ST_FETCH: begin
                if (i_fetch_done && cnt_r >= CNT_W'(SWITCH_MIN_CYC - 1)) begin
                    st_nxt    = ST_IDLE;
                    busy_nxt  = 1'b0;
                    count_nxt = count_r + 1'b1;
                    last_nxt  = cnt_r + 1'b1;
                    // Word zero now holds whatever the registers held
                    stale_nxt = zero_r;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Every flop is cleared by reset; nothing is left undefined
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_r      <= ST_IDLE;
            ctx_r     <= '{default: '0};
            rd_word_r <= '0;
            idx_r     <= '0;
            cnt_r     <= '0;
            base_r    <= '0;
            zero_r    <= 1'b0;
            stale_r   <= 1'b0;
            count_r   <= '0;
            last_r    <= '0;
            req_r     <= 1'b0;
            we_r      <= 1'b0;
            addr_r    <= '0;
            wdata_r   <= '0;
            pclr_r    <= 1'b0;
            tclr_r    <= 1'b0;
            fst_r     <= 1'b0;
            faddr_r   <= '0;
            busy_r    <= 1'b0;
            flags_r   <= '0;
        end else begin
            st_r      <= st_nxt;
            ctx_r     <= ctx_nxt;
            rd_word_r <= rd_word_nxt;
            idx_r     <= idx_nxt;
            cnt_r     <= cnt_nxt;
            base_r    <= base_nxt;
            zero_r    <= zero_nxt;
            stale_r   <= stale_nxt;
            count_r   <= count_nxt;
            last_r    <= last_nxt;
            req_r     <= req_nxt;
            we_r      <= we_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            pclr_r    <= pclr_nxt;
            tclr_r    <= tclr_nxt;
            fst_r     <= fst_nxt;
            faddr_r   <= faddr_nxt;
            busy_r    <= busy_nxt;
            flags_r   <= flags_nxt;
        end
    end

    // Bus slave: address and data held independently, one write at a time
    always_comb begin
        awh_nxt    = awh_r;
        awaddr_nxt = awaddr_r;
        wh_nxt     = wh_r;
        wdat_nxt   = wdat_r;
        wstb_nxt   = wstb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (s_axi_awvalid && !awh_r) begin
            awh_nxt    = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wh_r) begin
            wh_nxt   = 1'b1;
            wdat_nxt = s_axi_wdata;
            wstb_nxt = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            awh_nxt    = 1'b0;
            wh_nxt     = 1'b0;
            bvalid_nxt = 1'b1;
            if (awaddr_r == OFF_FLAGS || awaddr_r == OFF_POINTER) begin
                bresp_nxt = RESP_OKAY;
            end else if (awaddr_r == OFF_STATUS || awaddr_r == OFF_LASTLEN) begin
                bresp_nxt = RESP_OKAY;
            end else if (awaddr_r == OFF_COUNT) begin
                bresp_nxt = RESP_OKAY;
            end else begin
                bresp_nxt = RESP_SLVERR;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            if (s_axi_araddr == OFF_STATUS) begin
                rdata_nxt = {25'h0000000, stale_r, monitor, busy_r, 1'b0, st_r};
            end else if (s_axi_araddr == OFF_FLAGS) begin
                rdata_nxt = {24'h000000, flags_r};
            end else if (s_axi_araddr == OFF_POINTER) begin
                rdata_nxt = {24'h000000, pointer};
            end else if (s_axi_araddr == OFF_LASTLEN) begin
                rdata_nxt = {24'h000000, last_r};
            end else if (s_axi_araddr == OFF_COUNT) begin
                rdata_nxt = {16'h0000, count_r};
            end else begin
                rdata_nxt = '0;
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            awh_r    <= 1'b0;
            awaddr_r <= '0;
            wh_r     <= 1'b0;
            wdat_r   <= '0;
            wstb_r   <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= '0;
        end else begin
            awh_r    <= awh_nxt;
            awaddr_r <= awaddr_nxt;
            wh_r     <= wh_nxt;
            wdat_r   <= wdat_nxt;
            wstb_r   <= wstb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign s_axi_awready  = !awh_r;
    assign s_axi_wready   = !wh_r;
    assign s_axi_arready  = !rvalid_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rresp    = rresp_r;
    assign s_axi_rdata    = rdata_r;
    assign o_mem_req      = req_r;
    assign o_mem_we       = we_r;
    assign o_mem_addr     = addr_r;
    assign o_mem_wdata    = wdata_r;
    assign o_parcel_clear = pclr_r;
    assign o_tag_clear    = tclr_r;
    assign o_fetch_start  = fst_r;
    assign o_fetch_addr   = faddr_r;
    assign o_busy         = busy_r;
    assign o_monitor      = ctx_r[MODE_WORD][MON_BIT];

    // Reference counters read only by the checks below
    logic [4:0] a_rd_cnt, a_wr_cnt;
    always_ff @(posedge i_clock) begin
        if (i_srst || st_r == ST_HOLD) begin
            a_rd_cnt <= '0;
            a_wr_cnt <= '0;
        end else if (req_r && i_mem_ack) begin
            a_rd_cnt <= a_rd_cnt + {4'h0, !we_r};
            a_wr_cnt <= a_wr_cnt + {4'h0, we_r};
        end
    end

    default clocking a_clk @(posedge i_clock); endclocking
    default disable iff (i_srst);

    sequence s_swap_begin;
        st_r == ST_HOLD && hold_go ##1 st_r == ST_READ;
    endsequence
    sequence s_swap_end;
        st_r == ST_PAD && cnt_r >= CNT_W'(SWAP_MIN_CYC - 1) ##1 st_r == ST_FETCH;
    endsequence

    a_ref_counts: assert property (st_r == ST_WRITE && i_mem_ack && idx_r == 4'hF
        |=> a_rd_cnt == 5'h10 && a_wr_cnt == 5'h10)
        else $error("swap did not make 16 reads and 16 writes");
    a_hold_blocks: assert property (st_r == ST_HOLD && !hold_go |=> st_r == ST_HOLD)
        else $error("swap started while memory or registers busy");
    a_min_switch: assert property ($fell(busy_r) |-> last_r >= CNT_W'(SWITCH_MIN_CYC))
        else $error("context switch shorter than 83 cycles");
    a_tas_clear: assert property (st_r == ST_HOLD && hold_go && i_tas_holding
        |=> o_parcel_clear && ctx_r[MODE_WORD][WS_BIT]
            && ctx_r[P_WORD][P_W-1:0] == $past(i_tas_addr))
        else $error("stalled test-and-set not handled");
    a_block_addr: assert property (req_r |-> addr_r[ADDR_W-1:IDX_W]
        == {{(ADDR_W-PTR_W-IDX_W){1'b0}}, base_r})
        else $error("memory reference outside the selected block");
    a_word_order: assert property (s_swap_begin |-> addr_r[IDX_W-1:0] == 4'h0 && !we_r)
        else $error("swap did not begin with word zero");
    a_deadstart_ptr: assert property (st_r == ST_IDLE && i_deadstart
        |=> pointer == '0 ##[1:40] base_r == '0)
        else $error("deadstart did not use block zero");
    a_exit_flag: assert property (i_exit_normal && !monitor |=> flags_r[FLAG_NEX])
        else $error("normal exit flag not set outside monitor mode");
    a_monitor_mask: assert property (st_r == ST_IDLE && monitor
        && !flags_r[FLAG_MEM] && !start_zero && !exit_any
        |=> st_r == ST_IDLE)
        else $error("masked interrupt started a swap in monitor mode");
    a_tag_clear: assert property (s_swap_begin |-> o_tag_clear)
        else $error("buffer tags not cleared at swap start");
    a_fetch_addr: assert property (s_swap_end |-> o_fetch_start
        && o_fetch_addr == ctx_r[P_WORD][P_W-1:0])
        else $error("fetch not started at the restored address");
endmodule // ccx_sequencer

// >>> ccx_sequencer_note_end.sv
// Intentionally empty compile unit
`timescale 1ns/1ns

// >>> ccx_mem_model.sv
// Central memory model holding context packages, with adjustable grant delay
`timescale 1ns/1ns
module ccx_mem_model (
    input  wire logic        i_clock,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [21:0] i_addr,
    input  wire logic [63:0] i_wdata,
    output logic             o_ack,
    output logic [63:0]      o_rdata
);
    logic [63:0] mem [0:4095];
    logic [3:0]  wait_r = 4'h0;
    initial o_ack = 1'b0;
    initial o_rdata = 64'h0;
    always @(posedge i_clock) begin
        if (i_req && !o_ack && wait_r >= i_delay) begin
            o_ack <= 1'b1;
            wait_r <= 4'h0;
            if (i_we) mem[i_addr[11:0]] <= i_wdata;
            o_rdata <= i_we ? ~o_rdata : mem[i_addr[11:0]];
        end else begin
            o_ack <= 1'b0;
            // Data toggles outside a grant so a late sample never looks valid
            o_rdata <= ~o_rdata;
            wait_r <= (i_req && !o_ack) ? wait_r + 4'h1 : 4'h0;
        end
    end
endmodule // ccx_mem_model

// >>> ccx_sequencer_tb.sv
// Self-checking bench for the context exchange sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module ccx_sequencer_tb;
    import ccx_pkg::*;
    logic i_clock = 0, i_srst = 1, i_mem_pending = 0, i_reg_busy = 0, i_tas_holding = 0;
    logic i_fetch_done = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [4:0] trig = 0;
    logic [3:0] dly = 0, s_axi_wstrb = 4'hF;
    logic [7:0] i_intr_flags = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [23:0] i_tas_addr = 24'h00ABCD, i_prog_addr = 24'h001234;
    logic [31:0] s_axi_wdata = 0, rdv;
    logic [1:0] rsp, s_axi_bresp, s_axi_rresp;
    logic i_deadstart, i_scan_intr, i_ipi_start, i_exit_normal, i_exit_error, i_mem_ack;
    logic o_mem_req, o_mem_we, o_parcel_clear, o_tag_clear, o_fetch_start, o_busy, o_monitor;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    logic [21:0] o_mem_addr;
    logic [63:0] i_mem_rdata, o_mem_wdata;
    logic [23:0] o_fetch_addr;
    logic [17:0] base;
    logic [4:0] tv [3] = '{5'h10, 5'h08, 5'h04};
    int num_errors = 0, tests_run = 0, rds, wrs, bad, cyc, tg, pc, fs;
    assign {i_deadstart, i_scan_intr, i_ipi_start, i_exit_normal, i_exit_error} = trig;
    ccx_sequencer ccx_sequencer_inst (.*);
    ccx_mem_model ccx_mem_model_inst (.i_clock(i_clock), .i_delay(dly), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    initial forever #25 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (o_mem_req && i_mem_ack) begin
            // Read of word n must precede its write, words in rising order
            if (o_mem_addr !== {base, 4'((rds + wrs) / 2)} || o_mem_we !== 1'((rds + wrs) % 2))
                bad++;
            if (o_mem_we) wrs++;
            else rds++;
        end
        if (o_busy) cyc++;
        if (o_tag_clear) tg++;
        if (o_parcel_clear) pc++;
        if (o_fetch_start) fs++;
    end
    task pkg(input int b, input [7:0] ptr, input [23:0] p, input [1:0] m);
        ccx_mem_model_inst.mem[b * 16] = {56'h0, ptr};
        ccx_mem_model_inst.mem[b * 16 + 1] = {40'h0, p};
        ccx_mem_model_inst.mem[b * 16 + 2] = {62'h0, m};
    endtask
    task swap(input [4:0] t, input [7:0] f, input [17:0] b, input hold, input [23:0] p);
        base = b;
        {rds, wrs, bad, cyc, tg, pc, fs} = '0;
        @(posedge i_clock);
        trig <= t;
        i_intr_flags <= f;
        @(posedge i_clock);
        trig <= 0;
        i_intr_flags <= 0;
        if (hold) begin
            repeat (10) @(negedge i_clock);
            `CHK(rds + wrs, 0)
            @(posedge i_clock);
            {i_mem_pending, i_reg_busy} <= 2'b00;
        end
        repeat (3000) begin
            @(negedge i_clock);
            if (cyc > 0 && !o_busy) break;
        end
        `CHK(rds, 16)
        `CHK(wrs, 16)
        `CHK(bad, 0)
        `CHK(tg, 1)
        `CHK(pc, i_tas_holding)
        `CHK(cyc >= 83, 1)
        `CHK(o_fetch_addr, p)
        `CHK(fs, 1)
        `CHK(o_busy, 1'b0)
        $display("Swap test done at %0t", $time);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge i_clock);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        repeat (100) begin
            @(posedge i_clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        `CHK(s_axi_bvalid, 1'b1)
        `CHK(s_axi_bresp, RESP_OKAY)
        s_axi_bready <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        repeat (100) begin
            @(posedge i_clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        `CHK(s_axi_rvalid, 1'b1)
        {rdv, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_srst <= 0;
        foreach (tv[k]) begin
            pkg(0, 8'h02, 24'h100 + k, 2'h1);
            swap(tv[k], 8'h00, 18'h0, 0, 24'h100 + k);
        end
        rd(OFF_STATUS);
        `CHK(rdv[6], 1'b1)
        pkg(2, 8'h00, 24'h200, 2'h0);
        swap(5'h02, 8'h00, 18'h2, 0, 24'h200);
        `CHK(ccx_mem_model_inst.mem[32][7:0], 8'h02)
        `CHK(ccx_mem_model_inst.mem[33][23:0], i_prog_addr)
        rd(OFF_FLAGS);
        `CHK(rdv[FLAG_NEX], 1'b0)
        wr(OFF_POINTER, 32'h5);
        rd(OFF_POINTER);
        `CHK(rdv[7:0], 8'h00)
        pkg(0, 8'h02, 24'h400, 2'h1);
        {i_tas_holding, i_mem_pending, i_reg_busy, dly} <= {3'b111, 4'h3};
        swap(5'h00, 8'h08, 18'h0, 1, 24'h400);
        `CHK(ccx_mem_model_inst.mem[1][23:0], i_tas_addr)
        `CHK(ccx_mem_model_inst.mem[2][1], 1'b1)
        {i_tas_holding, dly} <= 5'h0;
        wr(OFF_FLAGS, 32'hFF);
        i_intr_flags <= 8'h08;
        @(posedge i_clock);
        i_intr_flags <= 0;
        repeat (10) @(negedge i_clock);
        `CHK(o_busy, 1'b0)
        wr(OFF_FLAGS, 32'hFF);
        wr(OFF_POINTER, 32'h3);
        rd(OFF_POINTER);
        `CHK(rdv[7:0], 8'h03)
        pkg(3, 8'h00, 24'h500, 2'h0);
        swap(5'h01, 8'h00, 18'h3, 0, 24'h500);
        rd(OFF_FLAGS);
        `CHK(rdv[FLAG_EEX], 1'b0)
        // User-mode exit: flag must be set, then stay masked in the monitor
        pkg(0, 8'h00, 24'h300, 2'h1);
        swap(5'h02, 8'h00, 18'h0, 0, 24'h300);
        rd(OFF_FLAGS);
        `CHK(rdv[FLAG_NEX], 1'b1)
        `CHK(o_busy, 1'b0)
        `CHK(o_monitor, 1'b1)
        rd(OFF_COUNT);
        `CHK(rdv[15:0], 16'h0007)
        rd(OFF_LASTLEN);
        `CHK(rdv[7:0] >= 8'h53, 1'b1)
        rd(8'h40);
        `CHK(rsp, RESP_SLVERR)
        $display("Register test done at %0t", $time);
        end_sim;
    end
endmodule // ccx_sequencer_tb
